//--- logic/rfts_params.svh
// named offsets, field positions, reset values and rates of the timer unit
// assumes inclusion by bare name from the package and the timer unit file
`ifndef RFTS_PARAMS_SVH
`define RFTS_PARAMS_SVH

// register indices; byte address is four times the index
`define RFTS_IDX_T0_HI       6'h12
`define RFTS_IDX_T0_LO       6'h13
`define RFTS_IDX_T1_CTRL     6'h14
`define RFTS_IDX_T1_RLD_HI   6'h15
`define RFTS_IDX_T1_RLD_LO   6'h16
`define RFTS_IDX_TCONTROL    6'h20
`define RFTS_IDX_IRQ_STATUS  6'h21

// shared timer-control and irq-status field positions
`define RFTS_BIT_T1_RUN      5
`define RFTS_BIT_T0_RUN      4
`define RFTS_BIT_T1_WE       1
`define RFTS_BIT_T0_WE       0
`define RFTS_BIT_T1_IRQ      0

// start-mode encodings
`define RFTS_START_MANUAL    2'h0
`define RFTS_START_TX_END    2'h1
`define RFTS_START_TRIM      2'h2
`define RFTS_START_TRIM_UF   2'h3

// tick source encodings
`define RFTS_CLK_CARRIER     2'h0
`define RFTS_CLK_SLOW        2'h1
`define RFTS_CLK_T0_UF       2'h2
`define RFTS_CLK_T2_UF       2'h3

// reset values and the fixed timer0 reload value
`define RFTS_CTRL_RESET      8'h00
`define RFTS_RELOAD_RESET    8'h00
`define RFTS_T0_RELOAD       16'hffff

// rates: slow tick is the carrier divided down
`define RFTS_CARRIER_HZ      13560000
`define RFTS_SLOW_HZ         211875
`define RFTS_SLOW_DIV        (`RFTS_CARRIER_HZ / `RFTS_SLOW_HZ)

// axi responses
`define RFTS_RESP_OKAY       2'h0
`define RFTS_RESP_SLVERR     2'h2

`endif

//--- logic/rfts_pkg.sv
// types shared by the timer unit files
// assumes rfts_params.svh sits on the include path
`default_nettype none
`include "rfts_params.svh"
package rfts_pkg;

    // timer1 control register layout
    typedef struct packed {
        logic       stop_on_receive;
        logic       rsv6;
        logic [1:0] start_mode;
        logic       auto_reload;
        logic       rsv2;
        logic [1:0] tick_source_select;
    } rfts_ctrl_t;

    // one register write from the bus slave
    typedef struct packed {
        logic       en;
        logic [5:0] idx;
        logic [7:0] data;
        logic       lane0;
    } rfts_wr_t;

endpackage
`default_nettype wire

//--- logic/rfts_down_counter.sv
// one 16-bit down counter with load, stop, reload and underflow pulse
// assumes start/stop/tick are one-cycle pulses on aclk
`timescale 1ns/1ns
`default_nettype none
module rfts_down_counter #(
    parameter int W = 16
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic         tick,
    input  wire logic [W-1:0] reload,
    input  wire logic         auto_reload,
    input  wire logic         hold_at_zero,
    output logic      [W-1:0] count,
    output logic              active,
    output logic              underflow
);
    logic [W-1:0] cnt_q, cnt_d;
    logic         act_q, act_d;
    logic         uf_q, uf_d;

    // stop beats start; reload only sampled at a start or an underflow
    always_comb begin
        cnt_d = cnt_q;
        act_d = act_q;
        uf_d  = 1'b0;
        if (stop) begin
            act_d = 1'b0;
        end else if (start) begin
            cnt_d = reload;
            act_d = 1'b1;
        end else if (act_q && tick) begin
            if (cnt_q == '0) begin
                if (!hold_at_zero) begin
                    uf_d = 1'b1;
                    if (auto_reload) begin
                        cnt_d = reload;
                    end else begin
                        act_d = 1'b0;
                    end
                end
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            act_q <= 1'b0;
            uf_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            act_q <= act_d;
            uf_q  <= uf_d;
        end
    end

    assign count     = cnt_q;
    assign active    = act_q;
    assign underflow = uf_q;
endmodule
`default_nettype wire

//--- logic/rfts_axil_slave.sv
// axi4-lite slave front end: one write and one read in flight
// assumes the parent decodes indices combinationally
`timescale 1ns/1ns
`default_nettype none
module rfts_axil_slave
    import rfts_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    output rfts_pkg::rfts_wr_t wr,
    input  wire logic          wr_ok,
    output logic [5:0]         rd_idx,
    input  wire logic [7:0]    rd_data,
    input  wire logic          rd_ok
);
    logic          awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
    logic          awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
    logic [AW-1:0] aa_q, aa_d;
    logic [7:0]    wd_q, wd_d;
    logic          ws_q, ws_d;
    logic [1:0]    br_q, br_d, rr_q, rr_d;
    logic [31:0]   rd_q, rd_d;

    assign rd_idx   = araddr[7:2];
    assign wr.en    = awh_q && wh_q && !bv_q;
    assign wr.idx   = aa_q[7:2];
    assign wr.data  = wd_q;
    assign wr.lane0 = ws_q;

    // address and data are caught in either order, answer after both
    always_comb begin
        awh_d = awh_q;
        wh_d  = wh_q;
        aa_d  = aa_q;
        wd_d  = wd_q;
        ws_d  = ws_q;
        bv_d  = bv_q;
        br_d  = br_q;
        rv_d  = rv_q;
        rr_d  = rr_q;
        rd_d  = rd_q;
        if (awvalid && awr_q) begin
            awh_d = 1'b1;
            aa_d  = awaddr;
        end
        if (wvalid && wr_q) begin
            wh_d = 1'b1;
            wd_d = wdata[7:0];
            ws_d = wstrb[0];
        end
        if (bv_q && bready) begin
            bv_d = 1'b0;
        end
        if (wr.en) begin
            awh_d = 1'b0;
            wh_d  = 1'b0;
            bv_d  = 1'b1;
            br_d  = wr_ok ? `RFTS_RESP_OKAY : `RFTS_RESP_SLVERR;
        end
        if (rv_q && rready) begin
            rv_d = 1'b0;
        end
        if (arvalid && arr_q) begin
            rv_d = 1'b1;
            rd_d = {24'h000000, rd_data};
            rr_d = rd_ok ? `RFTS_RESP_OKAY : `RFTS_RESP_SLVERR;
        end
        // readies drop while a channel is held or an answer waits
        awr_d = !awh_d && !bv_d;
        wr_d  = !wh_d && !bv_d;
        arr_d = !rv_d;
    end

    // registers only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awh_q <= 1'b0;
            wh_q  <= 1'b0;
            aa_q  <= '0;
            wd_q  <= 8'h00;
            ws_q  <= 1'b0;
            bv_q  <= 1'b0;
            br_q  <= `RFTS_RESP_OKAY;
            rv_q  <= 1'b0;
            rr_q  <= `RFTS_RESP_OKAY;
            rd_q  <= 32'h00000000;
            awr_q <= 1'b0;
            wr_q  <= 1'b0;
            arr_q <= 1'b0;
        end else begin
            awh_q <= awh_d;
            wh_q  <= wh_d;
            aa_q  <= aa_d;
            wd_q  <= wd_d;
            ws_q  <= ws_d;
            bv_q  <= bv_d;
            br_q  <= br_d;
            rv_q  <= rv_d;
            rr_q  <= rr_d;
            rd_q  <= rd_d;
            awr_q <= awr_d;
            wr_q  <= wr_d;
            arr_q <= arr_d;
        end
    end

    assign awready = awr_q;
    assign wready  = wr_q;
    assign bvalid  = bv_q;
    assign bresp   = br_q;
    assign arready = arr_q;
    assign rvalid  = rv_q;
    assign rresp   = rr_q;
    assign rdata   = rd_q;
endmodule
`default_nettype wire

//--- logic/rfts_timer_unit.sv
// reader timer unit: timer0 count readback and timer1 with control,
// reload, start modes, cascading and an underflow flag
// assumes carrier_tick, tx_done, rx_first_bits and timer2_underflow are
// one-cycle pulses synchronous to aclk, trim_ref a synchronous level
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "rfts_params.svh"

module rfts_timer_unit
    import rfts_pkg::*;
#(
    parameter int AW    = 8,
    parameter int CNT_W = 16
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    input  wire logic          carrier_tick,
    input  wire logic          tx_done,
    input  wire logic          rx_first_bits,
    input  wire logic          trim_ref,
    input  wire logic          timer2_underflow,
    output logic               timer1_irq_flag
);
    import rfts_pkg::*;

    localparam int DIV_W = $clog2(`RFTS_SLOW_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(`RFTS_SLOW_DIV - 1);

    rfts_wr_t         wr;
    logic             wr_ok;
    logic [5:0]       rd_idx;
    logic [7:0]       rd_data;
    logic             rd_ok;

    rfts_ctrl_t       ctrl_q, ctrl_d;
    logic [7:0]       rld_hi_q, rld_hi_d;
    logic [7:0]       rld_lo_q, rld_lo_d;
    logic             irq_q, irq_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic             slow_q, slow_d;
    logic             trim_q, trim_d;

    logic [CNT_W-1:0] t0_count, t1_count;
    logic             t0_active, t1_active;
    logic             t0_uf, t1_uf;
    logic             t0_start, t0_stop, t1_start, t1_stop;
    logic             t1_tick, trim_mode, trim_rise, wr_lane, tcon_wr;

    // bus front end
    rfts_axil_slave #(
        .AW(AW)
    ) u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr      (wr),
        .wr_ok   (wr_ok),
        .rd_idx  (rd_idx),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // index decode shared by both directions
    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx == `RFTS_IDX_T0_HI) || (idx == `RFTS_IDX_T0_LO) ||
                 (idx == `RFTS_IDX_T1_CTRL) || (idx == `RFTS_IDX_T1_RLD_HI) ||
                 (idx == `RFTS_IDX_T1_RLD_LO) || (idx == `RFTS_IDX_TCONTROL) ||
                 (idx == `RFTS_IDX_IRQ_STATUS);
    endfunction

    assign wr_ok   = mapped(wr.idx);
    assign wr_lane = wr.en && wr.lane0;  // only byte lane 0 carries data
    assign tcon_wr = wr_lane && (wr.idx == `RFTS_IDX_TCONTROL);

    // read mux; count bytes sampled live, so a read mid-reception
    // may catch a moving value, software is told to avoid that
    always_comb begin
        rd_ok   = mapped(rd_idx);
        rd_data = 8'h00;
        unique case (rd_idx)
            `RFTS_IDX_T0_HI:      rd_data = t0_count[15:8];
            `RFTS_IDX_T0_LO:      rd_data = t0_count[7:0];
            `RFTS_IDX_T1_CTRL:    rd_data = ctrl_q;
            `RFTS_IDX_T1_RLD_HI:  rd_data = rld_hi_q;
            `RFTS_IDX_T1_RLD_LO:  rd_data = rld_lo_q;
            `RFTS_IDX_TCONTROL: begin
                rd_data[`RFTS_BIT_T1_RUN] = t1_active;
                rd_data[`RFTS_BIT_T0_RUN] = t0_active;
            end
            `RFTS_IDX_IRQ_STATUS: rd_data[`RFTS_BIT_T1_IRQ] = irq_q;
            default:              rd_data = 8'h00;
        endcase
    end

    // software-held state: control, reload bytes, interrupt flag
    always_comb begin
        ctrl_d   = ctrl_q;
        rld_hi_d = rld_hi_q;
        rld_lo_d = rld_lo_q;
        irq_d    = irq_q;
        if (wr_lane) begin
            unique case (wr.idx)
                `RFTS_IDX_T1_CTRL: begin
                    ctrl_d      = wr.data;
                    ctrl_d.rsv6 = 1'b0;
                    ctrl_d.rsv2 = 1'b0;
                end
                // reload bytes feed the counter only at a start or an auto-reload underflow
                `RFTS_IDX_T1_RLD_HI:  rld_hi_d = wr.data;
                `RFTS_IDX_T1_RLD_LO:  rld_lo_d = wr.data;
                `RFTS_IDX_IRQ_STATUS: begin
                    if (wr.data[`RFTS_BIT_T1_IRQ]) begin
                        irq_d = 1'b0;                                // write one to clear
                    end
                end
                default: ;
            endcase
        end
        // set after clear so an underflow in the clear cycle survives
        if (t1_uf) begin
            irq_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q   <= `RFTS_CTRL_RESET;
            rld_hi_q <= `RFTS_RELOAD_RESET;
            rld_lo_q <= `RFTS_RELOAD_RESET;
            irq_q    <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            rld_hi_q <= rld_hi_d;
            rld_lo_q <= rld_lo_d;
            irq_q    <= irq_d;
        end
    end

    assign timer1_irq_flag = irq_q;

    // slow tick: every n-th carrier tick, so it stays phase locked to it
    always_comb begin
        div_d  = div_q;
        slow_d = 1'b0;
        if (carrier_tick) begin
            if (div_q == DIV_LAST) begin
                div_d  = '0;
                slow_d = 1'b1;
            end else begin
                div_d = div_q + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q  <= '0;
            slow_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            slow_q <= slow_d;
        end
    end

    // trimming reference edge detector; input already synchronous
    assign trim_d    = trim_ref;
    assign trim_rise = trim_ref && !trim_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_q <= 1'b0;
        end else begin
            trim_q <= trim_d;
        end
    end

    // timer0: only start and stop from software, fixed full-range reload
    assign t0_start = tcon_wr && wr.data[`RFTS_BIT_T0_WE] &&
                      wr.data[`RFTS_BIT_T0_RUN];
    assign t0_stop  = tcon_wr && wr.data[`RFTS_BIT_T0_WE] &&
                      !wr.data[`RFTS_BIT_T0_RUN];

    rfts_down_counter #(
        .W(CNT_W)
    ) u_t0 (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .start        (t0_start),
        .stop         (t0_stop),
        .tick         (carrier_tick),
        .reload       (`RFTS_T0_RELOAD),
        .auto_reload  (1'b1),
        .hold_at_zero (1'b0),
        .count        (t0_count),
        .active       (t0_active),
        .underflow    (t0_uf)
    );

    // timer1 tick source
    always_comb begin
        unique case (ctrl_q.tick_source_select)
            `RFTS_CLK_CARRIER: t1_tick = carrier_tick;
            `RFTS_CLK_SLOW:    t1_tick = slow_q;
            `RFTS_CLK_T0_UF:   t1_tick = t0_uf;
            `RFTS_CLK_T2_UF:   t1_tick = timer2_underflow;
        endcase
    end

    // timer1 start and stop events; a stop wins over a start in the
    // same cycle, the safe choice when a frame ends as software stops
    assign trim_mode = ctrl_q.start_mode[1];

    always_comb begin
        t1_start = 1'b0;
        t1_stop  = 1'b0;
        if (tcon_wr && wr.data[`RFTS_BIT_T1_WE]) begin
            t1_start = wr.data[`RFTS_BIT_T1_RUN];
            t1_stop  = !wr.data[`RFTS_BIT_T1_RUN];
        end
        unique case (ctrl_q.start_mode)
            `RFTS_START_MANUAL: ;
            `RFTS_START_TX_END: begin
                if (tx_done) begin
                    t1_start = 1'b1;
                end
            end
            `RFTS_START_TRIM, `RFTS_START_TRIM_UF: begin
                if (trim_rise) begin
                    t1_start = t1_start || !t1_active;
                    t1_stop  = t1_stop || t1_active;
                end
            end
        endcase
        if (ctrl_q.stop_on_receive && !trim_mode && rx_first_bits) begin
            t1_stop = 1'b1;
        end
    end

    // timer1 counter: both reload bytes are taken together at a start
    rfts_down_counter #(
        .W(CNT_W)
    ) u_t1 (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .start        (t1_start),
        .stop         (t1_stop),
        .tick         (t1_tick),
        .reload       ({rld_hi_q, rld_lo_q}),
        .auto_reload  (ctrl_q.auto_reload),
        .hold_at_zero (ctrl_q.start_mode == `RFTS_START_TRIM),
        .count        (t1_count),
        .active       (t1_active),
        .underflow    (t1_uf)
    );

    // timer1 count readback lies outside this block's register map
    logic unused_t1_count;
    assign unused_t1_count = ^t1_count;
endmodule
`default_nettype wire

//--- sim/rfts_timer_unit_props.sv
// concurrent checks on the timer unit's bus and flag ports
// assumes one aclk domain with synchronous active-low aresetn
`timescale 1ns/1ns
`default_nettype none
module rfts_props #(
    parameter int AW = 8
) (
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire logic          awvalid,
    input wire logic          awready,
    input wire logic          wvalid,
    input wire logic          wready,
    input wire logic [1:0]    bresp,
    input wire logic          bvalid,
    input wire logic          bready,
    input wire logic [AW-1:0] araddr,
    input wire logic          arvalid,
    input wire logic          arready,
    input wire logic [31:0]   rdata,
    input wire logic [1:0]    rresp,
    input wire logic          rvalid,
    input wire logic          rready,
    input wire logic          timer1_irq_flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves taken in one edge
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence ctrl_read;
        arvalid && arready && araddr[7:2] == 6'h14;
    endsequence
    AST_WR_LATENCY: assert property (wr_taken |=> ##1 bvalid)
        else $error("write response not on time");
    AST_RD_LATENCY: assert property (arvalid && arready |=> rvalid)
        else $error("read response not on time");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response dropped early");
    AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    AST_AR_BLOCK: assert property (rvalid |-> !arready)
        else $error("read taken while response pending");
    AST_CTRL_RSV: assert property (ctrl_read |=> rdata[6] == 1'b0 && rdata[2] == 1'b0)
        else $error("reserved control bits read nonzero");
    AST_RDATA_HI: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("upper read bits nonzero");
    // the flag only clears by a host write, which lands with bvalid
    AST_IRQ_STICKY: assert property ($fell(timer1_irq_flag) |-> bvalid)
        else $error("irq flag cleared without a write");
endmodule
bind rfts_timer_unit rfts_props #(.AW(AW)) u_props (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .timer1_irq_flag);
`default_nettype wire

//--- sim/rfts_timer_unit_tb_top.sv
// self-checking bench for the timer unit, one task per scenario
// assumes logic/ files compiled first; inputs driven at rising edges
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module rfts_timer_unit_tb_top;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, timer1_irq_flag;
    logic        carrier_tick, tx_done, rx_first_bits, trim_ref, timer2_underflow;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp_q;
    logic        lag = 1'b0;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cyc = 0;
    rfts_timer_unit uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .carrier_tick, .tx_done, .rx_first_bits, .trim_ref,
        .timer2_underflow, .timer1_irq_flag);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic report_and_stop();
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, above the roughly 66k cycles the timer0 cascade needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // write: offer both halves, drop each once taken, hold bready to the answer;
    // with lag set, ready follows the answer so the slave must hold it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= !lag;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        resp_q = bresp;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !lag;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        resp_q = rresp;
        `CHK("rdata", {24'h0, e}, rdata)
    endtask
    // k: 0 carrier tick, 1 tx end, 2 rx bits, 3 timer2 underflow; settles after
    task automatic ev(input int k, input int n);
        repeat (n) begin
            @(posedge aclk);
            carrier_tick <= (k == 0);
            tx_done <= (k == 1);
            rx_first_bits <= (k == 2);
            timer2_underflow <= (k == 3);
            @(posedge aclk);
            {carrier_tick, tx_done, rx_first_bits, timer2_underflow} <= 4'h0;
        end
        repeat (3) @(posedge aclk);
    endtask
    // carrier held high for n edges in a row, then settles
    task automatic burst(input int n);
        @(posedge aclk);
        carrier_tick <= 1'b1;
        repeat (n) @(posedge aclk);
        carrier_tick <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic t_regs();
        rd(8'h50, 8'h00);
        wr(8'h50, 8'hff);
        `CHK("bresp", 2'h0, resp_q)
        rd(8'h50, 8'hbb);
        lag = 1'b1;
        wr(8'h54, 8'ha5);
        rd(8'h54, 8'ha5);
        lag = 1'b0;
        wr(8'h58, 8'h5a);
        rd(8'h58, 8'h5a);
        rd(8'hfc, 8'h00);
        `CHK("rresp", 2'h2, resp_q)
        wr(8'hfc, 8'h00);
        `CHK("bresp", 2'h2, resp_q)
    endtask
    task automatic t_timer0();
        wr(8'h80, 8'h11);
        ev(0, 5);
        rd(8'h48, 8'hff);
        rd(8'h4c, 8'hfa);
        wr(8'h80, 8'h01);
        wr(8'h80, 8'h20);
        rd(8'h80, 8'h00);
    endtask
    task automatic t_oneshot();
        wr(8'h50, 8'h00);
        wr(8'h54, 8'h00);
        wr(8'h58, 8'h03);
        ev(1, 1);
        rd(8'h80, 8'h00);
        wr(8'h50, 8'h10);
        ev(1, 1);
        rd(8'h80, 8'h20);
        ev(0, 3);
        `CHK("irq", 1'b0, timer1_irq_flag)
        ev(0, 1);
        `CHK("irq", 1'b1, timer1_irq_flag)
        rd(8'h80, 8'h00);
        wr(8'h84, 8'h01);
        `CHK("irq", 1'b0, timer1_irq_flag)
    endtask
    task automatic t_reload();
        wr(8'h50, 8'h18);
        ev(1, 1);
        wr(8'h58, 8'h09);
        ev(0, 4);
        `CHK("irq", 1'b1, timer1_irq_flag)
        rd(8'h80, 8'h20);
        wr(8'h80, 8'h02);
    endtask
    // trim modes: rx bits must not stop, reference rises start and stop
    task automatic t_trim();
        wr(8'h58, 8'h03);
        wr(8'h50, 8'hb0);
        wr(8'h84, 8'h01);
        @(posedge aclk) trim_ref <= 1'b1;
        ev(2, 1);
        rd(8'h80, 8'h20);
        ev(0, 4);
        `CHK("irq", 1'b1, timer1_irq_flag)
        @(posedge aclk) trim_ref <= 1'b0;
        wr(8'h50, 8'h20);
        wr(8'h84, 8'h01);
        @(posedge aclk) trim_ref <= 1'b1;
        ev(0, 5);
        `CHK("irq", 1'b0, timer1_irq_flag)
        rd(8'h80, 8'h20);
        @(posedge aclk) trim_ref <= 1'b0;
        @(posedge aclk) trim_ref <= 1'b1;
        rd(8'h80, 8'h00);
    endtask
    task automatic t_stoprx();
        wr(8'h50, 8'h90);
        wr(8'h54, 8'h01);
        ev(1, 1);
        rd(8'h80, 8'h20);
        ev(2, 1);
        rd(8'h80, 8'h00);
    endtask
    task automatic t_cascade();
        wr(8'h54, 8'h00);
        wr(8'h58, 8'h01);
        wr(8'h50, 8'h03);
        wr(8'h84, 8'h01);
        wr(8'h80, 8'h22);
        ev(2, 1);
        rd(8'h80, 8'h20);
        ev(0, 3);
        `CHK("irq", 1'b0, timer1_irq_flag)
        ev(3, 2);
        `CHK("irq", 1'b1, timer1_irq_flag)
    endtask
    // slow tick: two slow ticks lie within 65..128 carrier ticks, whatever
    // the divider phase; then timer1 ticked by timer0 underflow
    task automatic t_chain();
        wr(8'h50, 8'h01);
        wr(8'h84, 8'h01);
        wr(8'h80, 8'h22);
        burst(64);
        `CHK("irq", 1'b0, timer1_irq_flag)
        burst(64);
        `CHK("irq", 1'b1, timer1_irq_flag)
        wr(8'h58, 8'h00);
        wr(8'h50, 8'h02);
        wr(8'h84, 8'h01);
        wr(8'h80, 8'h33);
        burst(65535);
        `CHK("irq", 1'b0, timer1_irq_flag)
        burst(1);
        `CHK("irq", 1'b1, timer1_irq_flag)
    endtask
    // reset, then the scenarios in turn
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {carrier_tick, tx_done, rx_first_bits, trim_ref, timer2_underflow} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'h1};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_timer0();
        t_oneshot();
        t_reload();
        t_trim();
        t_stoprx();
        t_cascade();
        t_chain();
        report_and_stop();
    end
endmodule
`default_nettype wire
